// file: src/lphr_pkg.sv
/*
  Shared constants for the hit readout link: frame layout, timing counts
  and state encodings for both ends.
  Assumes one 200 MHz system clock shared by both ends and a one-cycle
  bunch-crossing strobe from the timing logic on that same clock.
*/
`default_nettype none

package lphr_pkg;

  // ==========================================================================
  // Frame layout
  localparam int unsigned HIT_W     = 64;
  localparam int unsigned BCC_W     = 5;
  localparam int unsigned L1C_W     = 4;
  localparam int unsigned PRE_W     = BCC_W + L1C_W;
  localparam int unsigned FRAME_W   = PRE_W + HIT_W;
  localparam int unsigned STAGE_W   = BCC_W + HIT_W;
  localparam int unsigned WORD_W    = 32;
  localparam int unsigned WORD_PAD  = WORD_W - PRE_W;
  localparam int unsigned WORDS_OUT = 3;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_PS     = 5000;
  localparam int unsigned BIT_RATE_MBPS     = 40;
  localparam int unsigned BIT_CYCLES        = 1000000 / (BIT_RATE_MBPS * CLK_PERIOD_PS);
  localparam int unsigned SAMPLE_AT         = BIT_CYCLES / 2;
  localparam int unsigned READOUT_LIMIT_NS  = 1500;
  localparam int unsigned READOUT_LIMIT_CYC = (READOUT_LIMIT_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned TMR_W             = 3;
  localparam int unsigned IDX_W             = 7;
  localparam int unsigned LATE_W            = 10;

  // ==========================================================================
  // States
  typedef enum logic [1:0] {
    FE_IDLE = 2'h1,
    FE_SEND = 2'h2
  } lphr_fe_state_type;

  typedef enum logic [3:0] {
    CN_WAIT  = 4'h1,
    CN_GRANT = 4'h2,
    CN_RECV  = 4'h4,
    CN_EMIT  = 4'h8
  } lphr_cn_state_type;

endpackage

`default_nettype wire

// file: src/lphr_link_if.sv
/*
  Point-to-point link between one front-end unit and its concentrator lane.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface lphr_link_if (
  input wire logic clk_sys_in
);
  logic event_valid_flag;
  logic transfer_grant;
  logic serial_data;
  logic serial_frame;

  modport frontend (
    input  clk_sys_in,
    input  transfer_grant,
    output event_valid_flag,
    output serial_data,
    output serial_frame
  );

  modport concentrator (
    input  clk_sys_in,
    input  event_valid_flag,
    input  serial_data,
    input  serial_frame,
    output transfer_grant
  );
endinterface : lphr_link_if

`default_nettype wire

// file: src/lphr_frontend.sv
/*
  Front-end readout end: samples the discriminator hits, holds them for the
  trigger latency, buffers accepted events and sends them as serial frames.
  Assumes bx_strobe_in and level1_accept_in come from timing logic on
  clk_sys_in; the hit pins are asynchronous to it.
*/
`timescale 1ns/1ps
`default_nettype none

module lphr_frontend #(
  parameter int unsigned L1_LATENCY = 100,
  parameter int unsigned BUF_DEPTH  = 8
) (
  input  wire logic                       clk_sys_in,
  input  wire logic                       srst_in,
  input  wire logic                       bx_strobe_in,
  input  wire logic                       level1_accept_in,
  input  wire logic [lphr_pkg::HIT_W-1:0] disc_hit_in,
  lphr_link_if.frontend                   link,
  output logic                            buf_overflow_out,
  output logic [$clog2(BUF_DEPTH+1)-1:0]  buf_level_out
);
  import lphr_pkg::*;

  localparam int unsigned PTR_W = $clog2(BUF_DEPTH);
  localparam int unsigned CNT_W = $clog2(BUF_DEPTH + 1);

  // ==========================================================================
  // Hit input synchronisers
  // The discriminator outputs are asynchronous; a bit is taken only once the
  // second and third stages agree, which also rejects one-cycle glitches.
  logic [HIT_W-1:0] hit_s1;
  logic [HIT_W-1:0] hit_s2;
  logic [HIT_W-1:0] hit_s3;
  logic [HIT_W-1:0] hit_word;
  wire  [HIT_W-1:0] next_hit_word;

  assign next_hit_word = (hit_s2 & hit_s3) | (hit_word & (hit_s2 ^ hit_s3));

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      hit_s1   <= '0;
      hit_s2   <= '0;
      hit_s3   <= '0;
      hit_word <= '0;
    end else begin
      hit_s1   <= disc_hit_in;
      hit_s2   <= hit_s1;
      hit_s3   <= hit_s2;
      hit_word <= next_hit_word;
    end
  end

  // ==========================================================================
  // Bunch-crossing counter and latency pipeline
  // The crossing number travels with each word so the frame reports the
  // crossing the hits belong to, not the one in which the trigger came.
  logic [BCC_W-1:0]   bunch_crossing_count;
  logic [STAGE_W-1:0] pipe [L1_LATENCY];
  wire  [STAGE_W-1:0] pipe_tail;

  assign pipe_tail = pipe[L1_LATENCY-1];

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      bunch_crossing_count <= '0;
    end else if (bx_strobe_in) begin
      bunch_crossing_count <= bunch_crossing_count + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      for (int i = 0; i < L1_LATENCY; i++) begin
        pipe[i] <= '0;
      end
    end else if (bx_strobe_in) begin
      pipe[0] <= {bunch_crossing_count, hit_word};
      for (int i = 1; i < L1_LATENCY; i++) begin
        pipe[i] <= pipe[i-1];
      end
    end
  end

  // ==========================================================================
  // Trigger decision at the pipeline end
  // The accept is qualified by the crossing strobe: it refers to the word
  // leaving the pipeline in that crossing, both being on the same clock.
  logic [L1C_W-1:0] trigger_count;
  wire              accept_now;
  wire              buf_full;
  wire              buf_empty;
  wire              push;
  wire              pop;

  assign accept_now = bx_strobe_in & level1_accept_in;
  assign push       = accept_now & ~buf_full;
  // Without an accept the tail word is simply overwritten next crossing

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      trigger_count    <= '0;
      buf_overflow_out <= 1'b0;
    end else if (accept_now) begin
      trigger_count <= trigger_count + 1'b1;
      if (buf_full) begin
        buf_overflow_out <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Readout buffer
  // Kept in trigger order; an accept into a full buffer is lost and the
  // overflow flag stays set until reset, the trigger count still advances so
  // the gap shows at the concentrator.
  logic [FRAME_W-1:0] buf_mem [BUF_DEPTH];
  logic [PTR_W-1:0]   wr_ptr;
  logic [PTR_W-1:0]   rd_ptr;
  logic [CNT_W-1:0]   buf_count;
  wire  [PTR_W-1:0]   next_wr_ptr;
  wire  [PTR_W-1:0]   next_rd_ptr;

  assign buf_full    = (buf_count == CNT_W'(BUF_DEPTH));
  assign buf_empty   = (buf_count == '0);
  assign next_wr_ptr = (wr_ptr == PTR_W'(BUF_DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  assign next_rd_ptr = (rd_ptr == PTR_W'(BUF_DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
  assign buf_level_out = buf_count;

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      buf_mem[wr_ptr] <= {pipe_tail[STAGE_W-1 -: BCC_W], trigger_count,
                          pipe_tail[HIT_W-1:0]};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      buf_count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= next_wr_ptr;
      end
      if (pop) begin
        rd_ptr <= next_rd_ptr;
      end
      if (push && !pop) begin
        buf_count <= buf_count + 1'b1;
      end else if (pop && !push) begin
        buf_count <= buf_count - 1'b1;
      end
    end
  end

  // ==========================================================================
  // Serial transmitter
  // A frame is the preamble (crossing count, trigger count) then the hits,
  // most significant bit first, each bit held BIT_CYCLES clocks.
  lphr_fe_state_type  state;
  logic [FRAME_W-1:0] tx_shift;
  logic [TMR_W-1:0]   bit_tmr;
  logic [IDX_W-1:0]   bit_idx;
  logic               frame_active;
  wire                bit_end;
  wire                last_bit;
  wire                start_tx;

  assign start_tx = (state == FE_IDLE) && !buf_empty && link.transfer_grant;
  assign pop      = start_tx;
  assign bit_end  = (bit_tmr == TMR_W'(BIT_CYCLES - 1));
  assign last_bit = (bit_idx == IDX_W'(FRAME_W - 1));

  // Valid follows the buffer, so it rises the cycle after the event enters
  assign link.event_valid_flag = (state == FE_IDLE) && !buf_empty;
  assign link.serial_data      = tx_shift[FRAME_W-1];
  assign link.serial_frame     = frame_active;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state        <= FE_IDLE;
      tx_shift     <= '0;
      bit_tmr      <= '0;
      bit_idx      <= '0;
      frame_active <= 1'b0;
    end else begin
      unique case (state)
        FE_IDLE: begin
          if (start_tx) begin
            tx_shift     <= buf_mem[rd_ptr];
            bit_tmr      <= '0;
            bit_idx      <= '0;
            frame_active <= 1'b1;
            state        <= FE_SEND;
          end
        end
        FE_SEND: begin
          if (bit_end) begin
            bit_tmr  <= '0;
            tx_shift <= {tx_shift[FRAME_W-2:0], 1'b0};
            bit_idx  <= bit_idx + 1'b1;
            if (last_bit) begin
              frame_active <= 1'b0;
              state        <= FE_IDLE;
            end
          end else begin
            bit_tmr <= bit_tmr + 1'b1;
          end
        end
      endcase
    end
  end

endmodule // lphr_frontend

`default_nettype wire

// file: src/lphr_concentrator.sv
/*
  Concentrator receive lane for one front-end unit: grants the transfer,
  deserialises the frame, checks the trigger count and emits 32-bit words.
  Assumes the same system clock and crossing strobe as the front end; one
  lane is instanced per front-end unit.
*/
`timescale 1ns/1ps
`default_nettype none

module lphr_concentrator (
  input  wire logic                        clk_sys_in,
  input  wire logic                        srst_in,
  input  wire logic                        bx_strobe_in,
  lphr_link_if.concentrator                link,
  output logic [lphr_pkg::WORD_W-1:0]      word_out,
  output logic                             word_valid_out,
  output logic                             preamble_err_out,
  output logic                             readout_late_out
);
  import lphr_pkg::*;

  // ==========================================================================
  // Lane state
  // No state is shared between lanes, so any number of lanes run side by side
  lphr_cn_state_type  state;
  logic [FRAME_W-1:0] rx_shift;
  logic [TMR_W-1:0]   bit_tmr;
  logic [IDX_W-1:0]   bit_idx;
  logic [L1C_W-1:0]   expect_count;
  logic [1:0]         word_idx;
  logic [LATE_W-1:0]  late_cnt;
  wire                sample_now;
  wire                frame_done;
  wire [WORD_W-1:0]   next_word;
  wire [L1C_W-1:0]    rx_trig_count;

  assign link.transfer_grant = (state == CN_GRANT);
  assign sample_now = (state == CN_RECV) && (bit_tmr == TMR_W'(SAMPLE_AT));
  assign frame_done = sample_now && (bit_idx == IDX_W'(FRAME_W - 1));
  // Read while the last bit is still being sampled, so the count sits one
  // place below its final position in the frame
  assign rx_trig_count = rx_shift[HIT_W+L1C_W-2 -: L1C_W];

  // Preamble word, then upper and lower hit halves
  assign next_word = (word_idx == 2'h0) ? {WORD_PAD'(0), rx_shift[FRAME_W-1 -: PRE_W]} :
                     (word_idx == 2'h1) ? rx_shift[HIT_W-1 -: WORD_W] :
                                          rx_shift[WORD_W-1:0];

  // ==========================================================================
  // Receive and emit
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state            <= CN_WAIT;
      rx_shift         <= '0;
      bit_tmr          <= '0;
      bit_idx          <= '0;
      expect_count     <= '0;
      word_idx         <= '0;
      late_cnt         <= '0;
      word_out         <= '0;
      word_valid_out   <= 1'b0;
      preamble_err_out <= 1'b0;
      readout_late_out <= 1'b0;
    end else begin
      word_valid_out <= 1'b0;
      unique case (state)
        CN_WAIT: begin
          if (link.event_valid_flag && !link.serial_frame) begin
            state <= CN_GRANT;
          end
        end
        CN_GRANT: begin
          if (link.serial_frame) begin
            bit_tmr <= TMR_W'(1);
            bit_idx <= '0;
            state   <= CN_RECV;
          end
        end
        CN_RECV: begin
          bit_tmr <= (bit_tmr == TMR_W'(BIT_CYCLES - 1)) ? '0 : bit_tmr + 1'b1;
          if (sample_now) begin
            rx_shift <= {rx_shift[FRAME_W-2:0], link.serial_data};
            bit_idx  <= bit_idx + 1'b1;
          end
          if (frame_done) begin
            // Resynchronise on the received count so one gap flags once
            if (rx_trig_count != expect_count) begin
              preamble_err_out <= 1'b1;
            end
            expect_count <= rx_trig_count + 1'b1;
            word_idx     <= '0;
            late_cnt     <= '0;
            state        <= CN_EMIT;
          end
        end
        CN_EMIT: begin
          // Words leave at the crossing rate; the budget is checked per lane
          late_cnt <= late_cnt + 1'b1;
          if (late_cnt == LATE_W'(READOUT_LIMIT_CYC)) begin
            readout_late_out <= 1'b1;
          end
          if (bx_strobe_in) begin
            word_out       <= next_word;
            word_valid_out <= 1'b1;
            word_idx       <= word_idx + 1'b1;
            if (word_idx == 2'(WORDS_OUT - 1)) begin
              state <= CN_WAIT;
            end
          end
        end
      endcase
    end
  end

endmodule // lphr_concentrator

`default_nettype wire

// file: verification/lphr_link_props.sv
/*
  Protocol checks on the front-end to concentrator link.
  Assumes plain copies of the link signals, all on the shared system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module lphr_link_props (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic event_valid_flag,
  input wire logic transfer_grant,
  input wire logic serial_data,
  input wire logic serial_frame
);
  import lphr_pkg::*;
  localparam int unsigned FRAME_CYC = FRAME_W * BIT_CYCLES;
  logic [9:0] frame_cnt;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (srst_in);

  // ==========================================================================
  // Cycles spent inside the current frame
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || !serial_frame) frame_cnt <= 10'h0;
    else frame_cnt <= frame_cnt + 10'h1;
  end

  // ==========================================================================
  // Handshake steps
  sequence s_take;
    event_valid_flag && transfer_grant;
  endsequence
  sequence s_start;
    $rose(serial_frame);
  endsequence

  AST_GRANT_NEEDS_VALID: assert property ($rose(transfer_grant) |-> $past(event_valid_flag))
    else $error("grant raised with no event pending");
  AST_FRAME_AFTER_TAKE: assert property (s_take |=> s_start)
    else $error("frame did not start after grant");
  AST_START_NEEDS_GRANT: assert property (s_start |-> $past(transfer_grant))
    else $error("frame started without grant");
  AST_GRANT_DROPS: assert property (s_start |=> !transfer_grant)
    else $error("grant held after frame start");
  AST_GRANT_HELD: assert property (transfer_grant |-> event_valid_flag || serial_frame)
    else $error("grant without pending event");
  AST_FRAME_LENGTH: assert property ($fell(serial_frame) |-> frame_cnt == FRAME_CYC)
    else $error("frame length wrong");
  AST_BIT_HOLD: assert property (serial_frame && (frame_cnt % BIT_CYCLES != 0) |-> $stable(serial_data))
    else $error("serial bit changed inside its slot");
  AST_VALID_QUIET: assert property (serial_frame |-> !event_valid_flag)
    else $error("valid high during a frame");
  AST_FRAME_GAP: assert property ($fell(serial_frame) |-> !serial_frame [*8])
    else $error("frames too close");
endmodule // lphr_link_props

`default_nettype wire

// file: verification/l1_pipeline_hit_readout_test.sv
/*
  Self-checking bench: front end and concentrator lane joined by the link.
  Assumes the lphr package and both design ends; hits change just after a strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module l1_pipeline_hit_readout_test;
  import lphr_pkg::*;
  localparam int unsigned LAT = 4;
  logic                clk_sys_in, srst_in, bx_strobe_in, level1_accept_in;
  logic [HIT_W-1:0]    disc_hit_in;
  logic                buf_overflow_out, word_valid_out, preamble_err_out, readout_late_out;
  logic [3:0]          buf_level_out;
  logic [WORD_W-1:0]   word_out;
  logic [WORD_W-1:0]   got_q[$], exp_q[$];
  logic [FRAME_W-1:0]  frm_q[$], efrm_q[$], frm_sr;
  bit                  accept_map [2048];
  int                  fail_count, total_checks, sn, cyc, l1n, fcnt;

  lphr_link_if i_lphr_link_if (.clk_sys_in(clk_sys_in));
  lphr_frontend #(.L1_LATENCY(LAT), .BUF_DEPTH(8)) i_lphr_frontend (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .bx_strobe_in(bx_strobe_in),
    .level1_accept_in(level1_accept_in), .disc_hit_in(disc_hit_in), .link(i_lphr_link_if),
    .buf_overflow_out(buf_overflow_out), .buf_level_out(buf_level_out));
  lphr_concentrator i_lphr_concentrator (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .bx_strobe_in(bx_strobe_in), .link(i_lphr_link_if),
    .word_out(word_out), .word_valid_out(word_valid_out), .preamble_err_out(preamble_err_out),
    .readout_late_out(readout_late_out));
  lphr_link_props i_lphr_link_props (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .event_valid_flag(i_lphr_link_if.event_valid_flag),
    .transfer_grant(i_lphr_link_if.transfer_grant), .serial_data(i_lphr_link_if.serial_data),
    .serial_frame(i_lphr_link_if.serial_frame));

  function automatic logic [HIT_W-1:0] pat(input int k);
    pat = {32'h9e3779b9 * 32'(k), 32'ha5c30000 ^ 32'(k)};
  endfunction

  task automatic chk_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_frame(input logic [FRAME_W-1:0] got, input logic [FRAME_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Word judged at strobe m is the one sampled LAT strobes earlier
  task automatic accept_at(input int m, input bit lost);
    logic [FRAME_W-1:0] f;
    accept_map[m] = 1'b1;
    f = {5'(m - LAT), 4'(l1n), pat(m - LAT)};
    l1n++;
    if (!lost) begin
      efrm_q.push_back(f);
      exp_q.push_back({23'h0, f[FRAME_W-1 -: PRE_W]});
      exp_q.push_back(f[63:32]);
      exp_q.push_back(f[31:0]);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock, strobe every fifth cycle, hits and accepts
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  always @(negedge clk_sys_in) begin
    if (!srst_in) begin
      if (bx_strobe_in) begin
        sn = sn + 1;
        disc_hit_in = pat(sn);
      end
      bx_strobe_in = (cyc % 5 == 4);
      level1_accept_in = bx_strobe_in && accept_map[sn];
      cyc = cyc + 1;
    end
  end

  // ==========================================================================
  // Monitors: concentrator words and the serial wire itself
  always @(negedge clk_sys_in) begin
    if (word_valid_out === 1'b1) got_q.push_back(word_out);
    if (i_lphr_link_if.serial_frame === 1'b1) begin
      if (fcnt % BIT_CYCLES == SAMPLE_AT) frm_sr = {frm_sr[FRAME_W-2:0], i_lphr_link_if.serial_data};
      fcnt++;
    end else if (fcnt != 0) begin
      frm_q.push_back(frm_sr);
      fcnt = 0;
    end
  end

  initial begin
    #(20000 * 5);
    fail_count++;
    end_of_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    srst_in = 1'b1;
    bx_strobe_in = 1'b0;
    level1_accept_in = 1'b0;
    disc_hit_in = pat(0);
    accept_at(10, 1'b0);
    for (int m = 20; m <= 27; m++) accept_at(m, 1'b0);
    accept_at(28, 1'b1);
    accept_at(150, 1'b0);
    repeat (6) @(negedge clk_sys_in);
    srst_in = 1'b0;
    while (sn < 15) @(negedge clk_sys_in);
    chk_word(32'(buf_overflow_out), 32'h0);
    while (sn < 30) @(negedge clk_sys_in);
    chk_word(32'(buf_level_out), 32'h8);
    chk_word(32'(buf_overflow_out), 32'h1);
    while (got_q.size() < 27) @(negedge clk_sys_in);
    chk_word(32'(preamble_err_out), 32'h0);
    while (got_q.size() < 30) @(negedge clk_sys_in);
    repeat (20) @(negedge clk_sys_in);
    chk_word(32'(preamble_err_out), 32'h1);
    chk_word(32'(readout_late_out), 32'h0);
    chk_word(32'(got_q.size()), 32'(exp_q.size()));
    chk_word(32'(frm_q.size()), 32'(efrm_q.size()));
    foreach (exp_q[i]) chk_word(got_q[i], exp_q[i]);
    foreach (efrm_q[i]) chk_frame(frm_q[i], efrm_q[i]);
    end_of_test();
  end
endmodule // l1_pipeline_hit_readout_test

`default_nettype wire
